// file: logic/slc_pkg.sv
// Package: constants and types of the source lock controller
package slc_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ  = 20_000_000;
	localparam int TB_HZ   = 10_000_000; // Time base
	localparam int REF_HZ  = 50_000;     // Comparison rate
	localparam int REF_DIV = (CLK_HZ / TB_HZ) * (TB_HZ / REF_HZ);
	localparam int REF_HALF = REF_DIV / 2;
	localparam int SWEEP_CYC  = 16;  // Cycles per filter step
	localparam int SETTLE_CYC = 64;  // Loop settling per gain step
	// ****************************************
	// Frequency units are 100 kHz
	// ****************************************
	localparam logic [17:0] HARM_STEP  = 18'h007D0; // 200 MHz, 0.2 GHz
	localparam logic [17:0] HARM_HALF  = 18'h003E8;
	localparam logic [17:0] B2_STEP    = 18'h00004; // 400 kHz
	localparam logic [17:0] IF_MIN     = 18'h000FA; // 25 MHz
	localparam logic [17:0] IF_MAX     = 18'h00ABE; // 275 MHz
	localparam logic [17:0] IF_TOP     = 18'h00BB8; // 300 MHz
	localparam logic [6:0]  HARM_FIRST = 7'h05;
	localparam logic [6:0]  HARM_LAST  = 7'h5A;
	localparam logic [2:0]  GAIN_MAX   = 3'h7;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_TGT  = 4'h1;
	localparam logic [3:0] A_STAT = 4'h2;
	localparam logic [3:0] A_HARM = 4'h3;
	localparam logic [3:0] A_DIV  = 4'h4;
	localparam logic [3:0] A_IRQ  = 4'h5;
	localparam logic [3:0] A_MASK = 4'h6;
	localparam logic [3:0] A_MEAS = 4'h7;
	localparam int C_PRESET = 0;
	localparam int C_LOCK   = 1;
	localparam int C_ACQ    = 2;
	localparam int C_BAND   = 4;
	localparam int I_FOUND  = 0;
	localparam int I_LOCKED = 1;
	localparam int I_FAIL   = 2;
	localparam int I_REJECT = 3;
	localparam logic [1:0] BAND1 = 2'h0;
	localparam logic [1:0] BAND2 = 2'h1;
	localparam logic [1:0] BAND3 = 2'h2;

	typedef enum logic [1:0] {S_SCAN, S_SWEEP, S_SETTLE, S_SAMPLE} slc_st_t;

	typedef struct packed {
		slc_st_t            st;
		logic [1:0]         band;
		logic [17:0]        target;
		logic [17:0]        lock_f;
		logic [6:0]         harm;
		logic               harm_ok;
		logic [6:0]         tune;
		logic               tune_stb;
		logic [15:0]        ratio;
		logic [15:0]        divc;
		logic               div_o;
		logic               sig_q;
		logic               cnt_o;
		logic [8:0]         refc;
		logic               ref_o;
		logic [8:0]         phc;
		logic signed [15:0] perr;
		logic [2:0]         gain;
		logic               pol;
		logic signed [15:0] cv;
		logic [7:0]         wait_c;
		logic               lock_led;
		logic               preset_led;
		logic [3:0]         irq_st;
		logic [3:0]         irq_mask;
		logic               irq;
		logic [31:0]        rdata;
		logic [17:0]        meas;
	} slc_state_t;
endpackage

// file: logic/slc_ctrl.sv
// Module: source lock controller, divider, comparator, sweep and lock search
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module slc_ctrl (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Register port
	input  wire logic [3:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic      [31:0]        rdata,
	// Signal paths
	input  wire logic               sig_in,
	output logic                    count_out,
	output logic                    div_out,
	output logic                    ref_out,
	output logic signed [15:0]      phase_err,
	output logic signed [15:0]      ctl_volt,
	// Converter and counter
	input  wire logic               det_ok,
	input  wire logic [17:0]        count_in,
	output logic [6:0]              tune_code,
	output logic                    tune_stb,
	output logic [6:0]              harm_num,
	output logic                    if_valid,
	output logic [17:0]             meas_freq,
	// Loop status
	input  wire logic               loop_lock,
	input  wire logic               loop_bw,
	// Indicators
	output logic                    lock_led,
	output logic                    preset_led,
	output logic [1:0]              band_sel,
	output logic                    scan_active,
	output logic                    irq
);
	slc_pkg::slc_state_t s;
	slc_pkg::slc_state_t n;
	logic [17:0] ifr;
	logic [17:0] ref_f;
	logic        lock_ok;
	logic        wr_ctrl;
	logic [3:0]  ev;

	// ****************************************
	// Lock feasibility
	// ****************************************
	// Expected IF per band; band II sees the prescaled input
	always_comb begin
		ref_f = 18'(s.harm * slc_pkg::HARM_STEP);
		ifr = 18'h00000;
		lock_ok = 1'b0;
		case (s.band)
		slc_pkg::BAND1: begin
			ifr = s.target;
			lock_ok = ifr != 18'h00000 && ifr <= slc_pkg::IF_TOP;
		end
		slc_pkg::BAND2: begin
			ifr = (s.target + 18'h00002) / slc_pkg::B2_STEP;
			lock_ok = ifr != 18'h00000 && ifr <= slc_pkg::IF_TOP;
		end
		slc_pkg::BAND3: begin
			ifr = s.target - ref_f;
			lock_ok = s.harm_ok && s.target >= ref_f
				&& ifr >= slc_pkg::IF_MIN && ifr <= slc_pkg::IF_MAX;
		end
		default: begin
			ifr = 18'h00000;
			lock_ok = 1'b0;
		end
		endcase
	end

	assign wr_ctrl = wr && addr == slc_pkg::A_CTRL;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = s;
		ev = 4'h0;
		n.tune_stb = 1'b0;
		// Both paths see the same sample of the input
		n.sig_q = sig_in;
		n.cnt_o = sig_in;
		// Divider toggles every ratio/2 input edges for a 50 kHz square
		if (sig_in && !s.sig_q) begin
			if (s.divc >= (s.ratio >> 1) - 16'h0001) begin
				n.divc = 16'h0000;
				n.div_o = !s.div_o;
			end else begin
				n.divc = s.divc + 16'h0001;
			end
		end
		// Reference divided from the time base
		if (s.refc == 9'(slc_pkg::REF_HALF - 1)) begin
			n.refc = 9'h000;
			n.ref_o = !s.ref_o;
		end else begin
			n.refc = s.refc + 9'h001;
		end
		// Phase counted from reference rise, latched on divider rise
		n.phc = (!s.ref_o && n.ref_o) ? 9'h000 : s.phc + 9'h001;
		if (!s.div_o && n.div_o) begin
			n.perr = 16'(s.phc) - 16'(slc_pkg::REF_HALF);
		end
		// Correction only while the loop is closed or searching
		if (s.lock_led || s.st == slc_pkg::S_SETTLE || s.st == slc_pkg::S_SAMPLE) begin
			n.cv = 16'(s.pol ? -(s.perr * $signed({1'b0, s.gain}))
				: s.perr * $signed({1'b0, s.gain}));
		end else begin
			n.cv = 16'sh0000;
		end
		// In band III the measured value adds the known harmonic back
		n.meas = (s.band == slc_pkg::BAND3) ? ref_f + count_in : count_in;
		case (s.st)
		slc_pkg::S_SCAN: begin
			if (wr_ctrl && wdata[slc_pkg::C_PRESET]) begin
				n.tune = 7'((s.target + slc_pkg::HARM_HALF) / slc_pkg::HARM_STEP);
				n.tune_stb = 1'b1;
				n.preset_led = 1'b1;
			end else if (wr_ctrl && wdata[slc_pkg::C_LOCK]) begin
				if (lock_ok) begin
					n.lock_f = (s.band == slc_pkg::BAND2)
						? ifr * slc_pkg::B2_STEP : s.target;
					n.ratio = 16'(ifr << 1);
					n.divc = 16'h0000;
					n.gain = 3'h1;
					n.pol = 1'b0;
					n.wait_c = 8'h00;
					n.lock_led = 1'b0;
					n.st = slc_pkg::S_SETTLE;
				end else begin
					ev[slc_pkg::I_REJECT] = 1'b1;
				end
			end else if (wr_ctrl && wdata[slc_pkg::C_ACQ]) begin
				n.harm = slc_pkg::HARM_FIRST;
				n.harm_ok = 1'b0;
				n.wait_c = 8'h00;
				n.lock_led = 1'b0;
				n.preset_led = 1'b0;
				n.st = slc_pkg::S_SWEEP;
			end
		end
		slc_pkg::S_SWEEP: begin
			if (det_ok) begin
				// Hold the filter on this harmonic
				n.harm_ok = 1'b1;
				ev[slc_pkg::I_FOUND] = 1'b1;
				n.st = slc_pkg::S_SCAN;
			end else if (s.wait_c == 8'(slc_pkg::SWEEP_CYC - 1)) begin
				n.wait_c = 8'h00;
				n.harm = (s.harm == slc_pkg::HARM_LAST)
					? slc_pkg::HARM_FIRST : s.harm + 7'h01;
				n.tune = n.harm;
				n.tune_stb = 1'b1;
			end else begin
				n.wait_c = s.wait_c + 8'h01;
			end
		end
		slc_pkg::S_SETTLE: begin
			n.wait_c = s.wait_c + 8'h01;
			if (s.wait_c == 8'(slc_pkg::SETTLE_CYC - 1)) begin
				n.st = slc_pkg::S_SAMPLE;
			end
		end
		slc_pkg::S_SAMPLE: begin
			n.wait_c = 8'h00;
			if (loop_lock && loop_bw) begin
				n.lock_led = 1'b1;
				ev[slc_pkg::I_LOCKED] = 1'b1;
				n.st = slc_pkg::S_SCAN;
			end else if (s.gain != slc_pkg::GAIN_MAX) begin
				n.gain = s.gain + 3'h1;
				n.st = slc_pkg::S_SETTLE;
			end else if (!s.pol) begin
				n.pol = 1'b1;
				n.gain = 3'h1;
				n.st = slc_pkg::S_SETTLE;
			end else begin
				n.cv = 16'sh0000;
				n.gain = 3'h0;
				ev[slc_pkg::I_FAIL] = 1'b1;
				n.st = slc_pkg::S_SCAN;
			end
		end
		default: n.st = slc_pkg::S_SCAN;
		endcase
		// Register writes; commands above are pulses, not stored
		if (wr) begin
			case (addr)
			slc_pkg::A_CTRL: if (s.st == slc_pkg::S_SCAN) begin
				n.band = wdata[slc_pkg::C_BAND +: 2];
			end
			slc_pkg::A_TGT:  n.target = wdata[17:0];
			slc_pkg::A_MASK: n.irq_mask = wdata[3:0];
			default: n.band = n.band;
			endcase
		end
		// Write-one clears, but a new event in the same cycle wins
		n.irq_st = (s.irq_st & ~((wr && addr == slc_pkg::A_IRQ) ? wdata[3:0] : 4'h0)) | ev;
		n.irq = |(n.irq_st & n.irq_mask);
		// Read data valid in the cycle after the strobe only
		n.rdata = 32'h00000000;
		if (rd) begin
			case (addr)
			slc_pkg::A_CTRL: n.rdata = {26'h0, s.band, 4'h0};
			slc_pkg::A_TGT:  n.rdata = {14'h0, s.target};
			slc_pkg::A_STAT: n.rdata = {24'h0, s.gain, s.pol, s.st, s.harm_ok, s.lock_led};
			slc_pkg::A_HARM: n.rdata = {25'h0, s.harm};
			slc_pkg::A_DIV:  n.rdata = {16'h0, s.ratio};
			slc_pkg::A_IRQ:  n.rdata = {28'h0, s.irq_st};
			slc_pkg::A_MASK: n.rdata = {28'h0, s.irq_mask};
			slc_pkg::A_MEAS: n.rdata = {14'h0, s.meas};
			default:         n.rdata = 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign rdata       = s.rdata;
	assign count_out   = s.cnt_o;
	assign div_out     = s.div_o;
	assign ref_out     = s.ref_o;
	assign phase_err   = s.perr;
	assign ctl_volt    = s.cv;
	assign tune_code   = s.tune;
	assign tune_stb    = s.tune_stb;
	assign harm_num    = s.harm;
	assign if_valid    = s.harm_ok;
	assign meas_freq   = s.meas;
	assign lock_led    = s.lock_led;
	assign preset_led  = s.preset_led;
	assign band_sel    = s.band;
	assign scan_active = s.st == slc_pkg::S_SCAN;
	assign irq         = s.irq;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_count_copy: assert property (count_out == $past(sig_in))
		else $error("count path not a copy of input");
	a_div_edge: assert property ($changed(div_out) |-> $past(sig_in && !s.sig_q))
		else $error("divider moved without input edge");
	a_ref_half: assert property ($rose(ref_out) |-> ##200 $fell(ref_out))
		else $error("reference half period wrong");
	a_sweep_hold: assert property (s.st == slc_pkg::S_SWEEP && det_ok
		|=> scan_active && if_valid && harm_num == $past(harm_num))
		else $error("sweep did not hold on detection");
	a_preset_round: assert property (wr_ctrl && wdata[0] && scan_active
		|=> tune_stb && tune_code == 7'(($past(s.target) + 18'h003E8) / 18'h007D0))
		else $error("preset not rounded to 0.2 GHz");
	a_lock_reject: assert property (wr_ctrl && wdata[1] && !wdata[0] && scan_active && !lock_ok
		|=> scan_active && s.irq_st[3])
		else $error("impossible lock not rejected");
	a_ratio_load: assert property (wr_ctrl && wdata[1] && !wdata[0] && scan_active && lock_ok
		|=> s.ratio == 16'($past(ifr) << 1))
		else $error("divider ratio not twice the IF");
	a_band2_round: assert property (s.band == 2'h1 && s.st == slc_pkg::S_SETTLE
		|-> s.lock_f[1:0] == 2'h0)
		else $error("band II lock not on 400 kHz");
	a_gain_step: assert property (s.st == slc_pkg::S_SAMPLE && !(loop_lock && loop_bw)
		&& s.gain != 3'h7 |=> s.gain == $past(s.gain) + 3'h1)
		else $error("gain did not step");
	a_fail_zero: assert property ($rose(s.irq_st[2]) |-> ctl_volt == 16'sh0000 && scan_active)
		else $error("failed lock left voltage on");
	a_meas_sum: assert property (s.band == 2'h2 && $stable(s.band)
		|=> meas_freq == 18'($past(s.harm) * 18'h007D0 + $past(count_in)))
		else $error("measured value not harmonic plus count");

	c_found: cover property (s.st == slc_pkg::S_SWEEP ##1 if_valid && scan_active);
	c_locked: cover property ($rose(lock_led));
	c_failed: cover property ($rose(s.irq_st[2]));
	c_rejected: cover property ($rose(s.irq_st[3]));
endmodule // slc_ctrl

// file: tb/slc_source_model.sv
// Partner model: frequency-modulatable source steered by the control voltage
`timescale 1ns/1ns
module slc_source_model #(
	parameter int BASE_HALF = 2
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Control in, signal out
	input  wire logic signed [15:0] ctl_volt,
	output logic                    sig_out
);
	int cnt;
	int half;

	// Positive voltage raises the frequency to pull a late divider edge forward
	always_comb begin
		half = BASE_HALF;
		if (ctl_volt > 16'sh0000) half = BASE_HALF - 1;
		if (ctl_volt < 16'sh0000) half = BASE_HALF + 1;
	end

	// Oscillator; BASE_HALF must stay at 2 or more so the fast setting is legal
	always_ff @(posedge clk) begin
		if (rst || cnt >= half - 1) begin
			cnt     <= 0;
			sig_out <= rst ? 1'b0 : ~sig_out;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // slc_source_model

// file: tb/slc_ctrl_tb.sv
// Testbench: source lock controller scenarios against a modulated source
`timescale 1ns/1ns
module slc_ctrl_tb;
	logic               clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, det_ok = 1'b0;
	logic               loop_lock = 1'b1, loop_bw = 1'b1;
	logic        [3:0]  addr = 4'h0;
	logic        [31:0] wdata = 32'h0, rdata;
	logic        [17:0] count_in = 18'h00064, meas_freq;
	logic signed [15:0] ctl_volt, phase_err;
	logic        [6:0]  tune_code, harm_num;
	logic               sig_in, count_out, div_out, ref_out, tune_stb, if_valid;
	logic               lock_led, preset_led, scan_active, irq;
	logic        [1:0]  band_sel;
	int                 errors = 0, n_compared = 0, cycles = 0;

	slc_ctrl uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sig_in(sig_in), .count_out(count_out), .div_out(div_out),
		.ref_out(ref_out), .phase_err(phase_err), .ctl_volt(ctl_volt), .det_ok(det_ok),
		.count_in(count_in), .tune_code(tune_code), .tune_stb(tune_stb),
		.harm_num(harm_num), .if_valid(if_valid), .meas_freq(meas_freq),
		.loop_lock(loop_lock), .loop_bw(loop_bw), .lock_led(lock_led),
		.preset_led(preset_led), .band_sel(band_sel), .scan_active(scan_active), .irq(irq));
	slc_source_model src (.clk(clk), .rst(rst), .ctl_volt(ctl_volt), .sig_out(sig_in));

	// ****************************************
	// Clock, hang guard, shared tasks
	// ****************************************
	always #25 clk = ~clk;
	// Whole run needs well under 6000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end
	task summarize;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask
	function logic pick(int w);
		return w == 0 ? ref_out : div_out;
	endfunction
	// Length of one full high phase, in clocks
	task half_per(input int w, output int n);
		int k;
		k = 0;
		while (pick(w) !== 1'b0 && k < 3000) begin @(negedge clk); k++; end
		while (pick(w) !== 1'b1 && k < 3000) begin @(negedge clk); k++; end
		n = 0;
		while (pick(w) === 1'b1 && n < 3000) begin @(negedge clk); n++; end
	endtask
	task wait_irq(input int lim, output int n);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin @(negedge clk); n++; end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task paths;
		int n;
		logic s;
		half_per(0, n);
		chk("ref half", slc_pkg::CLK_HZ / slc_pkg::REF_HZ / 2, n);
		repeat (6) begin
			@(negedge clk);
			s = sig_in;
			@(negedge clk);
			chk("count_out", {31'h0, s}, {31'h0, count_out});
		end
	endtask
	task regs;
		rd_chk("mask reset", slc_pkg::A_MASK, 32'h0);
		wr_reg(slc_pkg::A_MASK, 32'hF);
		rd_chk("mask", slc_pkg::A_MASK, 32'hF);
		rd_chk("unmapped", 4'h8, 32'h0);
	endtask
	task rejects;
		logic [1:0]  b [3];
		logic [17:0] t [3];
		b = '{2'h0, 2'h0, 2'h2};
		t = '{18'h00000, 18'h00BB9, 18'h00064};
		// First pass runs masked so the level output must stay low
		wr_reg(slc_pkg::A_MASK, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr_reg(slc_pkg::A_TGT, {14'h0, t[i]});
			wr_reg(slc_pkg::A_CTRL, {26'h0, b[i], 4'h0});
			wr_reg(slc_pkg::A_CTRL, {26'h0, b[i], 4'h2});
			rd_chk("reject irq", slc_pkg::A_IRQ, 32'h8);
			chk("band_sel", {30'h0, b[i]}, {30'h0, band_sel});
			chk("masked irq", (i == 0) ? 32'h0 : 32'h1, {31'h0, irq});
			wr_reg(slc_pkg::A_IRQ, 32'hF);
			wr_reg(slc_pkg::A_MASK, 32'hF);
		end
		repeat (2) @(negedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask
	task presets;
		logic [17:0] t [2];
		logic [6:0]  e [2];
		int          n;
		t = '{18'h00BB7, 18'h00BB8};
		e = '{7'h01, 7'h02};
		for (int i = 0; i < 2; i++) begin
			wr_reg(slc_pkg::A_TGT, {14'h0, t[i]});
			wr_reg(slc_pkg::A_CTRL, 32'h1);
			n = 0;
			do begin @(negedge clk); n++; end while (tune_stb !== 1'b1 && n < 4);
			chk("preset stb", 32'h1, {31'h0, tune_stb});
			chk("preset code", {25'h0, e[i]}, {25'h0, tune_code});
			chk("preset led", 32'h1, {31'h0, preset_led});
		end
	endtask
	task lock_ok(input logic [31:0] band, input logic [17:0] tgt, input logic [31:0] ratio);
		int n;
		wr_reg(slc_pkg::A_TGT, {14'h0, tgt});
		wr_reg(slc_pkg::A_CTRL, band);
		wr_reg(slc_pkg::A_CTRL, band | 32'h2);
		rd_chk("divider", slc_pkg::A_DIV, ratio);
		wait_irq(200, n);
		rd_chk("locked irq", slc_pkg::A_IRQ, 32'h2);
		chk("lock led", 32'h1, {31'h0, lock_led});
		wr_reg(slc_pkg::A_IRQ, 32'hF);
	endtask
	task lock_fail;
		int n;
		@(posedge clk);
		loop_lock <= 1'b0;
		wr_reg(slc_pkg::A_CTRL, 32'h2);
		wait_irq(2000, n);
		chk("search span", 32'h1, {31'h0, n >= 14 * 64 && n <= 14 * 68});
		rd_chk("fail irq", slc_pkg::A_IRQ, 32'h4);
		chk("ctl zero", 32'h0, {16'h0, ctl_volt});
		chk("scan", 32'h1, {31'h0, scan_active});
		wr_reg(slc_pkg::A_IRQ, 32'hF);
		half_per(1, n);
		chk("div half", 32'd400, n);
		chk("phase range", 32'h1, {31'h0, phase_err >= -16'sd200 && phase_err < 16'sd200});
		@(posedge clk);
		loop_lock <= 1'b1;
	endtask
	// Detector fires midway between the second and third filter steps
	task acquire;
		int s;
		wr_reg(slc_pkg::A_CTRL, 32'h24);
		s = 0;
		repeat (39) begin @(negedge clk); s += int'(tune_stb); end
		@(posedge clk);
		det_ok <= 1'b1;
		@(posedge clk);
		det_ok <= 1'b0;
		repeat (20) @(negedge clk);
		chk("sweep steps", 32'h1, {31'h0, s >= 2});
		chk("held code", 32'h7, {25'h0, tune_code});
		chk("harm", 32'h7, {25'h0, harm_num});
		chk("if valid", 32'h1, {31'h0, if_valid});
		chk("meas", 32'h3714, {14'h0, meas_freq});
		rd_chk("found irq", slc_pkg::A_IRQ, 32'h1);
		wr_reg(slc_pkg::A_IRQ, 32'hF);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk("reset scan", 32'h1, {31'h0, scan_active});
		chk("reset irq", 32'h0, {31'h0, irq});
		rst <= 1'b0;
		paths();
		regs();
		rejects();
		presets();
		lock_ok(32'h0, 18'h00064, 32'hC8);
		rd_chk("status", slc_pkg::A_STAT, 32'h21);
		lock_fail();
		acquire();
		lock_ok(32'h20, 18'h038A4, 32'h3E8);
		lock_ok(32'h10, 18'h00065, 32'h32);
		summarize();
	end
endmodule // slc_ctrl_tb
